// ===== hw/pfc_defs.vh
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PFC_IDX_FORM 15'h2050
`define PFC_IDX_ALG 15'h2051
`define PFC_IDX_RSV_A 15'h2052
`define PFC_IDX_RSV_B 15'h2053
`define PFC_IDX_VER 15'h2080
`define PFC_IDX_VER_RSV 15'h2081
`define PFC_IDX_PROJ_LO 15'h2082
`define PFC_IDX_PROJ_HI 15'h2083
`define PFC_IDX_MEMA_LO 15'h2400
`define PFC_IDX_MEMA_HI 15'h2e10
`define PFC_IDX_MEMB_LO 15'h3000
`define PFC_IDX_MEMB_HI 15'h4a10
// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define PFC_MEMA_DEPTH 2577
`define PFC_MEMA_AW 12
`define PFC_MEMB_DEPTH 6673
`define PFC_MEMB_AW 13
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PFC_IN0_AFF 0
`define PFC_IN0_MON 1
`define PFC_IN1_AFF 2
`define PFC_IN1_MON 3
`define PFC_RES_AFF 4
`define PFC_RES_MON 5
`define PFC_FORM_MASK 8'h3f
`define PFC_FORM_RST 8'h2a
`define PFC_ALG_RST 2'h0
`define PFC_ALG_SEC_PUB 2'h0
`define PFC_ALG_SEC_PRIV 2'h1
`define PFC_ALG_LADDER 2'h2
`define PFC_ALG_PUBLIC 2'h3
// ----------------------------------------
// Address regions and bus answers
// ----------------------------------------
`define PFC_RG_NONE 4'h0
`define PFC_RG_FORM 4'h1
`define PFC_RG_ALG 4'h2
`define PFC_RG_ZERO 4'h3
`define PFC_RG_VER 4'h4
`define PFC_RG_PLO 4'h5
`define PFC_RG_PHI 4'h6
`define PFC_RG_MEMA 4'h7
`define PFC_RG_MEMB 4'h8
`define PFC_RESP_OKAY 2'h0
`define PFC_RESP_SLVERR 2'h2
`endif

// ===== hw/pfc_operand_mem.v
`timescale 1ns/1ns
module pfc_operand_mem #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock
  input wire clk_in,
  // Bus port
  input wire a_en_in,
  input wire a_we_in,
  input wire [3:0] a_be_in,
  input wire [AW-1:0] a_addr_in,
  input wire [31:0] a_wdata_in,
  output reg [31:0] a_rdata_out,
  // Engine port
  input wire b_en_in,
  input wire b_we_in,
  input wire [AW-1:0] b_addr_in,
  input wire [31:0] b_wdata_in,
  output reg [31:0] b_rdata_out
);

  reg [31:0] mem [0:DEPTH-1];
  integer i;

  // Engine write lands last, so it wins a same-word clash
  always @(posedge clk_in) begin
    if (a_en_in && a_we_in) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (a_be_in[i]) begin
          mem[a_addr_in][i*8 +: 8] <= a_wdata_in[i*8 +: 8];
        end
      end
    end
    if (b_en_in && b_we_in) begin
      mem[b_addr_in] <= b_wdata_in;
    end
    if (a_en_in && !a_we_in) begin
      a_rdata_out <= mem[a_addr_in];
    end
    if (b_en_in && !b_we_in) begin
      b_rdata_out <= mem[b_addr_in];
    end
  end

endmodule

// ===== hw/pfc_config.v
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
// Operation
// - Config bit 4 picks affine (1) or Jacobian (0) ECC result point.
// - Config bit 5 picks Montgomery (1) or normal (0) result form.
// - Algorithm field, config bits 9:8, acts only for RSA exponentiation.
// - Code 00 runs secure exponentiation, public and private key, from B1.
// - Code 01 runs secure exponentiation, private key only, from B1.
// - Code 10 runs the Montgomery ladder exponentiation.
// - Code 11 runs non-secure public-key exponentiation, exponent from A1.
// - Version byte: minor version in bits 3:0, major in 7:4, read-only.
// - Bits 31:16 read project number, bits 15:8 reserved, read-only.
// - First 32-bit operand window, read/write, indices 2400 to 2E10.
// - Second 32-bit operand window, read/write, indices 3000 to 4A10.
// - Config bits 15:10 reserved, no function, reset to zero.
// - Config bits 3:0 pick affine/Montgomery form of both input operands.
`include "pfc_defs.vh"
module pfc_config #(
  // Arbitrary identity values
  parameter [3:0] MINOR_VERSION = 4'h1,
  parameter [3:0] MAJOR_VERSION = 4'h2,
  parameter [15:0] PROJECT_ID = 16'h5a3c
) (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // AXI4-Lite write address and data
  input wire [31:0] s_awaddr_in,
  input wire s_awvalid_in,
  output wire s_awready_out,
  input wire [31:0] s_wdata_in,
  input wire [3:0] s_wstrb_in,
  input wire s_wvalid_in,
  output wire s_wready_out,
  // AXI4-Lite write response
  output reg [1:0] s_bresp_out,
  output reg s_bvalid_out,
  input wire s_bready_in,
  // AXI4-Lite read
  input wire [31:0] s_araddr_in,
  input wire s_arvalid_in,
  output wire s_arready_out,
  output reg [31:0] s_rdata_out,
  output reg [1:0] s_rresp_out,
  output wire s_rvalid_out,
  input wire s_rready_in,
  // Engine operation kind
  input wire eng_op_ecc_in,
  input wire eng_op_rsa_modexp_in,
  // Engine operand port
  input wire eng_mem_en_in,
  input wire eng_mem_sel_in,
  input wire eng_mem_we_in,
  input wire [12:0] eng_mem_addr_in,
  input wire [31:0] eng_mem_wdata_in,
  output wire [31:0] eng_mem_rdata_out,
  // Form selects to engine
  output reg input0_affine_sel_out,
  output reg input0_montgomery_sel_out,
  output reg input1_affine_sel_out,
  output reg input1_montgomery_sel_out,
  output reg result_affine_sel_out,
  output reg result_montgomery_sel_out,
  // Exponentiation selects to engine
  output reg [1:0] exponent_algorithm_sel_out,
  output reg exp_secure_pub_priv_out,
  output reg exp_secure_priv_out,
  output reg exp_ladder_out,
  output reg exp_public_out,
  output reg exp_from_b1_out,
  output reg exp_from_a1_out
);

  // ----------------------------------------
  // Read states
  // ----------------------------------------
  localparam [3:0] RD_IDLE = 4'h1;
  localparam [3:0] RD_WAIT = 4'h2;
  localparam [3:0] RD_LOAD = 4'h4;
  localparam [3:0] RD_RESP = 4'h8;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function [3:0] pfc_region;
    input [31:0] addr;
    reg [14:0] idx;
    begin
      idx = addr[16:2];
      if (addr[31:17] != 15'h0000) begin
        pfc_region = `PFC_RG_NONE;
      end else if (idx == `PFC_IDX_FORM) begin
        pfc_region = `PFC_RG_FORM;
      end else if (idx == `PFC_IDX_ALG) begin
        pfc_region = `PFC_RG_ALG;
      end else if (idx == `PFC_IDX_RSV_A || idx == `PFC_IDX_RSV_B ||
                   idx == `PFC_IDX_VER_RSV) begin
        pfc_region = `PFC_RG_ZERO;
      end else if (idx == `PFC_IDX_VER) begin
        pfc_region = `PFC_RG_VER;
      end else if (idx == `PFC_IDX_PROJ_LO) begin
        pfc_region = `PFC_RG_PLO;
      end else if (idx == `PFC_IDX_PROJ_HI) begin
        pfc_region = `PFC_RG_PHI;
      end else if (idx >= `PFC_IDX_MEMA_LO &&
                   idx <= `PFC_IDX_MEMA_HI) begin
        pfc_region = `PFC_RG_MEMA;
      end else if (idx >= `PFC_IDX_MEMB_LO &&
                   idx <= `PFC_IDX_MEMB_HI) begin
        pfc_region = `PFC_RG_MEMB;
      end else begin
        pfc_region = `PFC_RG_NONE;
      end
    end
  endfunction

  function [12:0] pfc_word;
    input [31:0] addr;
    input is_b;
    reg [14:0] off;
    begin
      off = is_b ? (addr[16:2] - `PFC_IDX_MEMB_LO) :
                   (addr[16:2] - `PFC_IDX_MEMA_LO);
      pfc_word = off[12:0];
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] form;
  reg [1:0] alg;
  reg aw_held;
  reg w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [3:0] rd_state;
  reg [3:0] next_rd_state;
  reg [31:0] ar_addr;
  reg [3:0] rd_region;
  reg eng_sel_q;
  wire [3:0] wr_region;
  wire do_write;
  wire rd_take;
  wire [31:0] mema_rdata;
  wire [31:0] memb_rdata;
  wire [31:0] enga_rdata;
  wire [31:0] engb_rdata;

  assign wr_region = pfc_region(aw_addr);
  assign do_write = aw_held && w_held && !s_bvalid_out;
  assign s_awready_out = !aw_held && !s_bvalid_out;
  assign s_wready_out = !w_held && !s_bvalid_out;
  assign s_arready_out = (rd_state == RD_IDLE);
  assign s_rvalid_out = (rd_state == RD_RESP);
  assign rd_take = s_arvalid_in && s_arready_out;
  assign eng_mem_rdata_out = eng_sel_q ? engb_rdata : enga_rdata;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_bvalid_out <= 1'b0;
      s_bresp_out <= `PFC_RESP_OKAY;
      form <= `PFC_FORM_RST;
      alg <= `PFC_ALG_RST;
    end else begin
      if (s_awvalid_in && s_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr_in;
      end
      if (s_wvalid_in && s_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_wdata_in;
        w_strb <= s_wstrb_in;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid_out <= 1'b1;
        if (wr_region == `PFC_RG_NONE) begin
          s_bresp_out <= `PFC_RESP_SLVERR;
        end else begin
          s_bresp_out <= `PFC_RESP_OKAY;
        end
        if (wr_region == `PFC_RG_FORM && w_strb[0]) begin
          form <= w_data[7:0] & `PFC_FORM_MASK;
        end
        if (wr_region == `PFC_RG_ALG && w_strb[0]) begin
          alg <= w_data[1:0];
        end
      end else if (s_bvalid_out && s_bready_in) begin
        s_bvalid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always @* begin
    next_rd_state = rd_state;
    case (rd_state)
      RD_IDLE: begin
        if (rd_take) begin
          next_rd_state = RD_WAIT;
        end
      end
      RD_WAIT: begin
        next_rd_state = RD_LOAD;
      end
      RD_LOAD: begin
        next_rd_state = RD_RESP;
      end
      RD_RESP: begin
        if (s_rready_in) begin
          next_rd_state = RD_IDLE;
        end
      end
      default: begin
        next_rd_state = RD_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_state <= RD_IDLE;
      ar_addr <= 32'h00000000;
      rd_region <= `PFC_RG_NONE;
      s_rdata_out <= 32'h00000000;
      s_rresp_out <= `PFC_RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      if (rd_take) begin
        ar_addr <= s_araddr_in;
        rd_region <= pfc_region(s_araddr_in);
      end
      if (rd_state == RD_LOAD) begin
        s_rresp_out <= `PFC_RESP_OKAY;
        case (rd_region)
          `PFC_RG_FORM: begin
            s_rdata_out <= {24'h000000, form};
          end
          `PFC_RG_ALG: begin
            s_rdata_out <= {30'h00000000, alg};
          end
          `PFC_RG_VER: begin
            s_rdata_out <= {24'h000000, MAJOR_VERSION,
                            MINOR_VERSION};
          end
          `PFC_RG_PLO: begin
            s_rdata_out <= {24'h000000, PROJECT_ID[7:0]};
          end
          `PFC_RG_PHI: begin
            s_rdata_out <= {24'h000000, PROJECT_ID[15:8]};
          end
          `PFC_RG_MEMA: begin
            s_rdata_out <= mema_rdata;
          end
          `PFC_RG_MEMB: begin
            s_rdata_out <= memb_rdata;
          end
          `PFC_RG_ZERO: begin
            s_rdata_out <= 32'h00000000;
          end
          default: begin
            s_rdata_out <= 32'h00000000;
            s_rresp_out <= `PFC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Operand memories
  // ----------------------------------------
  wire bus_rd_a = (rd_state == RD_WAIT) && (rd_region == `PFC_RG_MEMA);
  wire bus_rd_b = (rd_state == RD_WAIT) && (rd_region == `PFC_RG_MEMB);
  wire bus_wr_a = do_write && (wr_region == `PFC_RG_MEMA);
  wire bus_wr_b = do_write && (wr_region == `PFC_RG_MEMB);
  wire [31:0] bus_addr = do_write ? aw_addr : ar_addr;
  wire [3:0] bus_region = do_write ? wr_region : rd_region;
  wire [12:0] bus_word = pfc_word(bus_addr,
                                  bus_region == `PFC_RG_MEMB);

  pfc_operand_mem #(
    .DEPTH(`PFC_MEMA_DEPTH),
    .AW(`PFC_MEMA_AW)
  ) u_mem_first (
    .clk_in(clk_in),
    .a_en_in(bus_rd_a || bus_wr_a),
    .a_we_in(bus_wr_a),
    .a_be_in(w_strb),
    .a_addr_in(bus_word[11:0]),
    .a_wdata_in(w_data),
    .a_rdata_out(mema_rdata),
    .b_en_in(eng_mem_en_in && !eng_mem_sel_in),
    .b_we_in(eng_mem_we_in),
    .b_addr_in(eng_mem_addr_in[11:0]),
    .b_wdata_in(eng_mem_wdata_in),
    .b_rdata_out(enga_rdata)
  );

  pfc_operand_mem #(
    .DEPTH(`PFC_MEMB_DEPTH),
    .AW(`PFC_MEMB_AW)
  ) u_mem_second (
    .clk_in(clk_in),
    .a_en_in(bus_rd_b || bus_wr_b),
    .a_we_in(bus_wr_b),
    .a_be_in(w_strb),
    .a_addr_in(bus_word),
    .a_wdata_in(w_data),
    .a_rdata_out(memb_rdata),
    .b_en_in(eng_mem_en_in && eng_mem_sel_in),
    .b_we_in(eng_mem_we_in),
    .b_addr_in(eng_mem_addr_in),
    .b_wdata_in(eng_mem_wdata_in),
    .b_rdata_out(engb_rdata)
  );

  // ----------------------------------------
  // Engine selects
  // ----------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      eng_sel_q <= 1'b0;
      input0_affine_sel_out <= 1'b0;
      input0_montgomery_sel_out <= 1'b0;
      input1_affine_sel_out <= 1'b0;
      input1_montgomery_sel_out <= 1'b0;
      result_affine_sel_out <= 1'b0;
      result_montgomery_sel_out <= 1'b0;
      exponent_algorithm_sel_out <= 2'h0;
      exp_secure_pub_priv_out <= 1'b0;
      exp_secure_priv_out <= 1'b0;
      exp_ladder_out <= 1'b0;
      exp_public_out <= 1'b0;
      exp_from_b1_out <= 1'b0;
      exp_from_a1_out <= 1'b0;
    end else begin
      if (eng_mem_en_in && !eng_mem_we_in) begin
        eng_sel_q <= eng_mem_sel_in;
      end
      // Coordinate selects only mean something for ECC
      input0_affine_sel_out <= eng_op_ecc_in &&
                               form[`PFC_IN0_AFF];
      input1_affine_sel_out <= eng_op_ecc_in &&
                               form[`PFC_IN1_AFF];
      input0_montgomery_sel_out <= form[`PFC_IN0_MON];
      input1_montgomery_sel_out <= form[`PFC_IN1_MON];
      result_affine_sel_out <= eng_op_ecc_in &&
                               form[`PFC_RES_AFF];
      result_montgomery_sel_out <= form[`PFC_RES_MON];
      exponent_algorithm_sel_out <= alg;
      // Ignored outside RSA exponentiation
      exp_secure_pub_priv_out <= eng_op_rsa_modexp_in &&
                                 alg == `PFC_ALG_SEC_PUB;
      exp_secure_priv_out <= eng_op_rsa_modexp_in &&
                             alg == `PFC_ALG_SEC_PRIV;
      exp_ladder_out <= eng_op_rsa_modexp_in &&
                        alg == `PFC_ALG_LADDER;
      exp_public_out <= eng_op_rsa_modexp_in &&
                        alg == `PFC_ALG_PUBLIC;
      exp_from_b1_out <= eng_op_rsa_modexp_in &&
                         !alg[1];
      exp_from_a1_out <= eng_op_rsa_modexp_in &&
                         alg == `PFC_ALG_PUBLIC;
    end
  end

endmodule

// ===== testbench/pfc_config_sva.sv
`timescale 1ns/1ns
module pfc_config_sva (
  // Clock and reset
  input logic clk_in,
  input logic nrst_in,
  // Register bus
  input logic s_awvalid_in,
  input logic s_awready_out,
  input logic s_wvalid_in,
  input logic s_wready_out,
  input logic [1:0] s_bresp_out,
  input logic s_bvalid_out,
  input logic s_bready_in,
  input logic s_arvalid_in,
  input logic s_arready_out,
  input logic [31:0] s_rdata_out,
  input logic [1:0] s_rresp_out,
  input logic s_rvalid_out,
  input logic s_rready_in,
  // Engine side
  input logic eng_op_ecc_in,
  input logic eng_op_rsa_modexp_in,
  input logic input0_affine_sel_out,
  input logic input1_affine_sel_out,
  input logic result_affine_sel_out,
  input logic [1:0] exponent_algorithm_sel_out,
  input logic exp_secure_pub_priv_out,
  input logic exp_secure_priv_out,
  input logic exp_ladder_out,
  input logic exp_public_out,
  input logic exp_from_b1_out,
  input logic exp_from_a1_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  AST_WR_ANSWER: assert property (s_awvalid_in && s_awready_out &&
    s_wvalid_in && s_wready_out |=> !s_bvalid_out ##1 s_bvalid_out)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_bvalid_out && !s_bready_in
    |=> s_bvalid_out && $stable(s_bresp_out))
    else $error("write answer dropped");
  AST_RD_ANSWER: assert property (s_arvalid_in && s_arready_out
    |=> !s_rvalid_out [*2] ##1 s_rvalid_out)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_rvalid_out && !s_rready_in
    |=> s_rvalid_out && $stable(s_rdata_out) && $stable(s_rresp_out))
    else $error("read answer dropped");
  AST_AR_BLOCK: assert property (s_rvalid_out |-> !s_arready_out)
    else $error("read accepted while busy");
  // ----------------------------------------
  // Select decoding
  // ----------------------------------------
  AST_AFF_ECC: assert property (!eng_op_ecc_in |=> !result_affine_sel_out
    && !input0_affine_sel_out && !input1_affine_sel_out)
    else $error("affine select outside ecc");
  AST_NO_RSA: assert property (!eng_op_rsa_modexp_in |=> !(exp_ladder_out ||
    exp_secure_pub_priv_out || exp_secure_priv_out || exp_public_out ||
    exp_from_b1_out || exp_from_a1_out))
    else $error("algorithm decode outside modexp");
  AST_PUB_PRIV: assert property ($past(eng_op_rsa_modexp_in) |->
    exp_secure_pub_priv_out == (exponent_algorithm_sel_out == 2'h0))
    else $error("code 0 decode wrong");
  AST_PRIV: assert property ($past(eng_op_rsa_modexp_in) |->
    exp_secure_priv_out == (exponent_algorithm_sel_out == 2'h1) &&
    exp_from_b1_out == !exponent_algorithm_sel_out[1])
    else $error("code 1 decode wrong");
  AST_LADDER: assert property ($past(eng_op_rsa_modexp_in) |->
    exp_ladder_out == (exponent_algorithm_sel_out == 2'h2))
    else $error("code 2 decode wrong");
  AST_PUBLIC: assert property ($past(eng_op_rsa_modexp_in) |->
    exp_public_out == (exponent_algorithm_sel_out == 2'h3) &&
    exp_from_a1_out == (exponent_algorithm_sel_out == 2'h3))
    else $error("code 3 decode wrong");
  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cover property (eng_op_rsa_modexp_in && exp_ladder_out);
  cover property (result_affine_sel_out);
  cover property (s_rvalid_out && s_rready_in && s_rresp_out == 2'h2);
endmodule

bind pfc_config pfc_config_sva u_sva (.clk_in, .nrst_in, .s_awvalid_in,
  .s_awready_out, .s_wvalid_in, .s_wready_out, .s_bresp_out, .s_bvalid_out,
  .s_bready_in, .s_arvalid_in, .s_arready_out, .s_rdata_out, .s_rresp_out,
  .s_rvalid_out, .s_rready_in, .eng_op_ecc_in, .eng_op_rsa_modexp_in,
  .input0_affine_sel_out, .input1_affine_sel_out, .result_affine_sel_out,
  .exponent_algorithm_sel_out, .exp_secure_pub_priv_out, .exp_secure_priv_out,
  .exp_ladder_out, .exp_public_out, .exp_from_b1_out, .exp_from_a1_out);

// ===== testbench/pfc_config_tb_top.sv
`timescale 1ns/1ns
`include "pfc_defs.vh"
module pfc_config_tb_top;
  logic clk_in, nrst_in, s_awvalid_in, s_wvalid_in, s_bready_in;
  logic s_arvalid_in, s_rready_in, eng_op_ecc_in, eng_op_rsa_modexp_in;
  logic eng_mem_en_in, eng_mem_sel_in, eng_mem_we_in;
  logic [31:0] s_awaddr_in, s_wdata_in, s_araddr_in, eng_mem_wdata_in;
  logic [3:0] s_wstrb_in;
  logic [12:0] eng_mem_addr_in;
  wire s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
  wire [1:0] s_bresp_out, s_rresp_out, exponent_algorithm_sel_out;
  wire [31:0] s_rdata_out, eng_mem_rdata_out;
  wire input0_affine_sel_out, input0_montgomery_sel_out, input1_affine_sel_out;
  wire input1_montgomery_sel_out, result_affine_sel_out;
  wire result_montgomery_sel_out, exp_secure_pub_priv_out, exp_secure_priv_out;
  wire exp_ladder_out, exp_public_out, exp_from_b1_out, exp_from_a1_out;
  wire [5:0] form_sel = {result_montgomery_sel_out, result_affine_sel_out,
    input1_montgomery_sel_out, input1_affine_sel_out,
    input0_montgomery_sel_out, input0_affine_sel_out};
  wire [7:0] alg_sel = {exponent_algorithm_sel_out, exp_secure_pub_priv_out,
    exp_secure_priv_out, exp_ladder_out, exp_public_out, exp_from_b1_out,
    exp_from_a1_out};
  logic [31:0] adr [4] = '{32'h9000, 32'hb840, 32'hc000, 32'h12840};
  logic [31:0] bad [5] = '{32'hb844, 32'hbffc, 32'h12844, 32'h8150, 32'h29000};
  logic [7:0] fv [5] = '{8'h3f, 8'h15, 8'h2a, 8'h10, 8'h20};
  logic [1:0] ok, err;
  int bad_count, cmp_count;

  // Arbitrary identity values
  pfc_config #(.MINOR_VERSION(4'h1), .MAJOR_VERSION(4'h2),
    .PROJECT_ID(16'h5a3c)) dut (.clk_in, .nrst_in, .s_awaddr_in,
    .s_awvalid_in, .s_awready_out, .s_wdata_in, .s_wstrb_in, .s_wvalid_in,
    .s_wready_out, .s_bresp_out, .s_bvalid_out, .s_bready_in, .s_araddr_in,
    .s_arvalid_in, .s_arready_out, .s_rdata_out, .s_rresp_out, .s_rvalid_out,
    .s_rready_in, .eng_op_ecc_in, .eng_op_rsa_modexp_in, .eng_mem_en_in,
    .eng_mem_sel_in, .eng_mem_we_in, .eng_mem_addr_in, .eng_mem_wdata_in,
    .eng_mem_rdata_out, .input0_affine_sel_out, .input0_montgomery_sel_out,
    .input1_affine_sel_out, .input1_montgomery_sel_out, .result_affine_sel_out,
    .result_montgomery_sel_out, .exponent_algorithm_sel_out,
    .exp_secure_pub_priv_out, .exp_secure_priv_out, .exp_ladder_out,
    .exp_public_out, .exp_from_b1_out, .exp_from_a1_out);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] r);
    s_awaddr_in <= a;
    s_wdata_in <= d;
    s_wstrb_in <= s;
    s_awvalid_in <= 1'b1;
    s_wvalid_in <= 1'b1;
    s_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_awready_out) s_awvalid_in <= 1'b0;
      if (s_wready_out) s_wvalid_in <= 1'b0;
    end while (!s_bvalid_out);
    check({30'h0, s_bresp_out}, {30'h0, r});
    s_bready_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d,
    input logic [1:0] r);
    s_araddr_in <= a;
    s_arvalid_in <= 1'b1;
    s_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_arready_out) s_arvalid_in <= 1'b0;
    end while (!s_rvalid_out);
    check(s_rdata_out, d);
    check({30'h0, s_rresp_out}, {30'h0, r});
    s_rready_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic eng(input logic sel, input logic we, input logic [12:0] a,
    input logic [31:0] d);
    eng_mem_sel_in <= sel;
    eng_mem_we_in <= we;
    eng_mem_addr_in <= a;
    eng_mem_wdata_in <= d;
    eng_mem_en_in <= 1'b1;
    @(posedge clk_in);
    eng_mem_en_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic ops(input logic ecc, input logic rsa);
    eng_op_ecc_in <= ecc;
    eng_op_rsa_modexp_in <= rsa;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {nrst_in, s_awvalid_in, s_wvalid_in, s_bready_in, s_arvalid_in} = '0;
    {s_rready_in, eng_op_ecc_in, eng_op_rsa_modexp_in, eng_mem_en_in} = '0;
    {eng_mem_sel_in, eng_mem_we_in, eng_mem_addr_in, s_wstrb_in} = '0;
    {s_awaddr_in, s_wdata_in, s_araddr_in, eng_mem_wdata_in} = '0;
    ok = `PFC_RESP_OKAY;
    err = `PFC_RESP_SLVERR;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    // Reset values and identity
    rd(32'h8140, 32'h2a, ok);
    rd(32'h8144, 32'h0, ok);
    rd(32'h8148, 32'h0, ok);
    rd(32'h814c, 32'h0, ok);
    rd(32'h8204, 32'h0, ok);
    rd(32'h8200, 32'h21, ok);
    rd(32'h8208, 32'h3c, ok);
    rd(32'h820c, 32'h5a, ok);
    check({26'h0, form_sel}, 32'h2a);
    // Read-only and reserved places, and a write with no strobe bits, ignore writes
    wr(32'h8200, 32'hff, 4'hf, ok);
    rd(32'h8200, 32'h21, ok);
    wr(32'h8148, 32'hff, 4'hf, ok);
    rd(32'h8148, 32'h0, ok);
    wr(32'h8140, 32'h0, 4'h0, ok);
    rd(32'h8140, 32'h2a, ok);
    // Form selects with and without ECC
    for (int i = 0; i < 10; i++) begin
      wr(32'h8140, {24'h0, fv[i % 5] | 8'hc0}, 4'hf, ok);
      rd(32'h8140, {24'h0, fv[i % 5]}, ok);
      ops(i < 5, 1'b0);
      check(form_sel, fv[i % 5] & (i < 5 ? 8'h3f : 8'h2a));
      {eng_op_ecc_in, eng_op_rsa_modexp_in} <= 2'b00;
    end
    // Algorithm codes, with and without modular exponentiation
    for (int i = 0; i < 8; i++) begin
      wr(32'h8144, 32'hfc | (i % 4), 4'hf, ok);
      rd(32'h8144, i % 4, ok);
      ops(1'b0, i < 4);
      check(alg_sel, {i[1:0], (i < 4) ? {i == 0, i == 1, i == 2, i == 3,
        i < 2, i == 3} : 6'h0});
      {eng_op_ecc_in, eng_op_rsa_modexp_in} <= 2'b00;
    end
    // Operand windows at both ends
    for (int i = 0; i < 4; i++)
      wr(adr[i], adr[i] ^ 32'ha5a50000, 4'hf, ok);
    for (int i = 0; i < 4; i++)
      rd(adr[i], adr[i] ^ 32'ha5a50000, ok);
    wr(32'h9004, 32'hffffffff, 4'hf, ok);
    wr(32'h9004, 32'h0, 4'h5, ok);
    rd(32'h9004, 32'hff00ff00, ok);
    for (int i = 0; i < 5; i++) begin
      wr(bad[i], 32'h1, 4'hf, err);
      rd(bad[i], 32'h0, err);
    end
    // Engine side of the windows
    eng(1'b0, 1'b1, 13'h10, 32'h1234abcd);
    rd(32'h9040, 32'h1234abcd, ok);
    wr(32'hc014, 32'hcafe0001, 4'hf, ok);
    eng(1'b1, 1'b0, 13'h5, 32'h0);
    check(eng_mem_rdata_out, 32'hcafe0001);
    eng(1'b0, 1'b0, 13'ha10, 32'h0);
    check(eng_mem_rdata_out, 32'hb840 ^ 32'ha5a50000);
    print_verdict();
  end
endmodule
